// [urm_params.svh]
// Constants for the register map and interrupt enable block.
// Assumes inclusion by bare name from the design files.
`ifndef URM_PARAMS_SVH
`define URM_PARAMS_SVH
// Addresses A2..A0
`define URM_A_DATA 3'h0
`define URM_A_IER 3'h1
`define URM_A_ISR 3'h2
`define URM_A_LCR 3'h3
`define URM_A_MCR 3'h4
`define URM_A_LSR 3'h5
`define URM_A_MSR 3'h6
`define URM_A_SPR 3'h7
// Line control codes and bits
`define URM_ENH_CODE 8'hbf
`define URM_LCR_DL_BIT 7
`define URM_EFR_ENH_BIT 4
`define URM_FEATURE_CONTROL_SWAP_BIT 6
`define URM_ENHANCED_MODE_SELECT_IMD_BIT 6
`define URM_ENHANCED_MODE_SELECT_CNT_BIT 0
`define URM_FCR_EN_BIT 0
// Interrupt source codes
`define URM_ISR_LSR 6'h06
`define URM_ISR_RXRDY 6'h04
`define URM_ISR_TRANSMIT_READY_EVENT 6'h02
`define URM_ISR_MODEM 6'h00
`define URM_ISR_NONE 6'h01
// Reset values
`define URM_RST_BYTE 8'h00
`define URM_RST_LCR 8'h03
`define URM_RST_TRIG 8'h01
// Identity values are arbitrary
`define URM_REV_VAL 8'h11
`define URM_IDENT_VAL 8'h5a
`endif

// [urm_pkg.sv]
// Types shared by the register map and interrupt enable block.
// Assumes no other package.
package urm_pkg;
  typedef logic [7:0] urm_byte_type;
  typedef enum logic [1:0] {
    URM_BANK_NORMAL = 2'b00,
    URM_BANK_DIVISOR = 2'b01,
    URM_BANK_ENHANCED = 2'b10
  } urm_bank_type;
endpackage : urm_pkg

// [urm_regmap.sv]
// Register decode and interrupt enable logic of one serial channel.
// Assumes the host bus and datapath status run on clock_i, one-cycle strobes.
//
// What this block does
// - Divisor low, high, fraction at 0,1,2 only with divisor enable and not enhanced code.
// - Upper mask bits 7-4, FIFO control bits 5-4, modem bits 7-5 and fraction need enhanced-function bit 4.
// - Mask gates receive data, transmit empty, line status and modem status interrupts.
// - FIFO mode: receive interrupt while level at or above trigger, drops below clears.
// - Data ready sets when a character enters the FIFO, clears when FIFO empties.
// - FIFO on with mask bits 0-3 clear is polled mode, no interrupt except a line-status one still pending.
// - Line status bit 1 flags a receive overrun.
// - Line status bits 2-4 give parity, framing, break of the head byte.
// - Line status bit 5 high while transmit holding or FIFO is empty.
// - Line status bit 6 high only when transmit FIFO and shift register empty.
// - Line status bit 7 high when any FIFO character carries an error.
// - Mask bit 0 enables receive interrupt; held char or trigger level; resets 0.
// - Mask bit 1 enables transmit-ready on holding empty or below trigger; resets 0.
// - Enabling transmit-ready while holding register is empty interrupts at once.
// - Mask bit 2 enables line-status interrupt from status bits 1 to 4.
// - Overrun raises the line-status interrupt at once.
// - By default error interrupts fire when the bad character is read out.
// - Mode-select bit 6 set makes error interrupts fire on reception.
// - Mask bit 3 gates the modem-status interrupt, reset value 0.
// - Reading line status clears a pending line-status interrupt.
// - Reading interrupt status or writing transmit holding clears transmit-ready.
// - Modem-status interrupt raised when any modem status bit 0-3 is set.
`include "urm_params.svh"
`timescale 1ns/1ps
`default_nettype none
module urm_regmap (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Host register access
  input wire logic cs_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wr_data_i,
  output logic [7:0] rd_data_o,
  output logic irq_o,
  // Receive datapath status and transmit FIFO level
  input wire logic [7:0] rx_data_i,
  input wire logic [7:0] rx_level_i,
  input wire logic [7:0] tx_level_i,
  input wire logic rx_loaded_i,
  input wire logic [2:0] rx_new_err_i,
  input wire logic [2:0] rx_head_err_i,
  input wire logic rx_empty_i,
  input wire logic rx_overrun_i,
  input wire logic rx_fifo_err_i,
  // Transmit datapath status
  input wire logic tx_hold_empty_i,
  input wire logic tx_shift_empty_i,
  input wire logic tx_below_trig_i,
  // Modem change flags, bits 0-3, and modem levels
  input wire logic [3:0] modem_delta_i,
  input wire logic [3:0] modem_level_i,
  // Configuration to the datapath
  output logic [15:0] divisor_o,
  output logic [3:0] fraction_o,
  output logic [7:0] line_control_o,
  output logic [7:0] modem_control_o,
  output logic fifo_enable_o,
  output logic [7:0] rx_trigger_o,
  output logic tx_write_o,
  output logic [7:0] tx_data_o,
  output logic rx_read_o
);
  urm_pkg::urm_byte_type div_low_ff, div_high_ff, lcr_ff, ier_ff, mcr_ff, spr_ff;
  urm_pkg::urm_byte_type fcr_ff, trg_ff, feature_control_ff, efr_ff, enhanced_mode_select_ff;
  urm_pkg::urm_byte_type resume_char_one_ff, resume_char_two_ff, pause_char_one_ff, pause_char_two_ff;
  logic [3:0] frac_ff;
  logic ready_ff, overrun_ff, lsr_int_ff, tx_int_ff, tx_cond_ff;
  logic [3:0] msr_ff;
  urm_pkg::urm_bank_type bank;
  logic rd, wr, enh, div_zero, tx_cond, rx_avail, rhr_rd, thr_wr, lsr_rd, isr_rd, msr_rd;
  logic err_event, nxt_irq;
  urm_pkg::urm_byte_type nxt_rd_data, lsr_val, trig_lvl;
  logic [5:0] isr_code;

  assign rd = cs_i & rd_i;
  assign wr = cs_i & wr_i;
  assign enh = efr_ff[`URM_EFR_ENH_BIT];
  assign div_zero = (div_low_ff == `URM_RST_BYTE) && (div_high_ff == `URM_RST_BYTE);

  // Bank select from line control
  always_comb begin
    if (lcr_ff == `URM_ENH_CODE) begin
      bank = urm_pkg::URM_BANK_ENHANCED;
    end else if (lcr_ff[`URM_LCR_DL_BIT]) begin
      bank = urm_pkg::URM_BANK_DIVISOR;
    end else begin
      bank = urm_pkg::URM_BANK_NORMAL;
    end
  end

  assign rhr_rd = rd && (addr_i == `URM_A_DATA) && (bank == urm_pkg::URM_BANK_NORMAL);
  assign thr_wr = wr && (addr_i == `URM_A_DATA) && (bank == urm_pkg::URM_BANK_NORMAL);
  assign isr_rd = rd && (addr_i == `URM_A_ISR) && (bank == urm_pkg::URM_BANK_NORMAL ||
                  (bank == urm_pkg::URM_BANK_DIVISOR && !enh));
  assign lsr_rd = rd && (addr_i == `URM_A_LSR) && (bank != urm_pkg::URM_BANK_ENHANCED);
  assign msr_rd = rd && (addr_i == `URM_A_MSR) && (bank != urm_pkg::URM_BANK_ENHANCED);

  // Host register writes
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      div_low_ff <= `URM_RST_BYTE;
      div_high_ff <= `URM_RST_BYTE;
      frac_ff <= 4'h0;
      lcr_ff <= `URM_RST_LCR;
      ier_ff <= `URM_RST_BYTE;
      mcr_ff <= `URM_RST_BYTE;
      spr_ff <= `URM_RST_BYTE;
      fcr_ff <= `URM_RST_BYTE;
      trg_ff <= `URM_RST_TRIG;
      feature_control_ff <= `URM_RST_BYTE;
      efr_ff <= `URM_RST_BYTE;
      enhanced_mode_select_ff <= `URM_RST_BYTE;
      resume_char_one_ff <= `URM_RST_BYTE;
      resume_char_two_ff <= `URM_RST_BYTE;
      pause_char_one_ff <= `URM_RST_BYTE;
      pause_char_two_ff <= `URM_RST_BYTE;
    end else if (wr) begin
      unique case (addr_i)
        `URM_A_DATA: begin
          if (bank == urm_pkg::URM_BANK_DIVISOR) div_low_ff <= wr_data_i;
          if (bank == urm_pkg::URM_BANK_ENHANCED) trg_ff <= wr_data_i;
        end
        `URM_A_IER: begin
          if (bank == urm_pkg::URM_BANK_DIVISOR) div_high_ff <= wr_data_i;
          if (bank == urm_pkg::URM_BANK_ENHANCED) feature_control_ff <= wr_data_i;
          if (bank == urm_pkg::URM_BANK_NORMAL) begin
            ier_ff[3:0] <= wr_data_i[3:0];
            if (enh) ier_ff[7:4] <= wr_data_i[7:4];
          end
        end
        `URM_A_ISR: begin
          if (bank == urm_pkg::URM_BANK_ENHANCED) begin
            efr_ff <= wr_data_i;
          end else if (bank == urm_pkg::URM_BANK_DIVISOR && enh) begin
            frac_ff <= wr_data_i[3:0];
          end else if (wr_data_i[`URM_FCR_EN_BIT]) begin
            // Other bits only program while the enable bit is written as one
            fcr_ff[7:6] <= wr_data_i[7:6];
            fcr_ff[3:0] <= {wr_data_i[3], 2'b00, 1'b1};
            if (enh) fcr_ff[5:4] <= wr_data_i[5:4];
          end else begin
            fcr_ff[`URM_FCR_EN_BIT] <= 1'b0;
          end
        end
        `URM_A_LCR: lcr_ff <= wr_data_i;
        `URM_A_MCR: begin
          if (bank == urm_pkg::URM_BANK_ENHANCED) begin
            resume_char_one_ff <= wr_data_i;
          end else begin
            mcr_ff[4:0] <= wr_data_i[4:0];
            if (enh) mcr_ff[7:5] <= wr_data_i[7:5];
          end
        end
        `URM_A_LSR: if (bank == urm_pkg::URM_BANK_ENHANCED) resume_char_two_ff <= wr_data_i;
        `URM_A_MSR: if (bank == urm_pkg::URM_BANK_ENHANCED) pause_char_one_ff <= wr_data_i;
        `URM_A_SPR: begin
          if (bank == urm_pkg::URM_BANK_ENHANCED) pause_char_two_ff <= wr_data_i;
          else if (feature_control_ff[`URM_FEATURE_CONTROL_SWAP_BIT]) enhanced_mode_select_ff <= wr_data_i;
          else spr_ff <= wr_data_i;
        end
      endcase
    end
  end

  // Line status sticky bits; a set in the clearing cycle wins
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ready_ff <= 1'b0;
      overrun_ff <= 1'b0;
    end else begin
      ready_ff <= rx_loaded_i | (ready_ff & ~rx_empty_i);
      overrun_ff <= rx_overrun_i | (overrun_ff & ~lsr_rd);
    end
  end

  assign lsr_val = {rx_fifo_err_i,
                    tx_hold_empty_i & tx_shift_empty_i,
                    tx_hold_empty_i,
                    rx_head_err_i,
                    overrun_ff, ready_ff};

  // Error interrupt timing: immediate or at read-out
  assign err_event = rx_overrun_i |
                     (enhanced_mode_select_ff[`URM_ENHANCED_MODE_SELECT_IMD_BIT] ? (rx_loaded_i & |rx_new_err_i)
                                                 : (rhr_rd & |rx_head_err_i));

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      lsr_int_ff <= 1'b0;
    end else begin
      lsr_int_ff <= (ier_ff[2] & err_event) | (lsr_int_ff & ~lsr_rd);
    end
  end

  // Transmit ready: edge of the empty condition, or enable set while empty
  assign tx_cond = fifo_enable_o ? tx_below_trig_i : tx_hold_empty_i;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tx_cond_ff <= 1'b0;
      tx_int_ff <= 1'b0;
    end else begin
      tx_cond_ff <= tx_cond;
      if ((ier_ff[1] & tx_cond & ~tx_cond_ff) ||
          (wr && addr_i == `URM_A_IER && bank == urm_pkg::URM_BANK_NORMAL &&
           wr_data_i[1] && !ier_ff[1] && tx_hold_empty_i)) begin
        tx_int_ff <= 1'b1;
      end else if (isr_rd || thr_wr || !ier_ff[1]) begin
        tx_int_ff <= 1'b0;
      end
    end
  end

  // Modem status flags, cleared by reading modem status
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      msr_ff <= 4'h0;
    end else begin
      msr_ff <= modem_delta_i | (msr_ff & {4{~msr_rd}});
    end
  end

  // Receive available: trigger level in FIFO mode, held char otherwise
  assign trig_lvl = (trg_ff == `URM_RST_BYTE) ? `URM_RST_TRIG : trg_ff;
  assign rx_avail = fifo_enable_o ? (rx_level_i >= trig_lvl) : ready_ff;

  always_comb begin
    if (lsr_int_ff) begin
      isr_code = `URM_ISR_LSR;
    end else if (ier_ff[0] & rx_avail) begin
      isr_code = `URM_ISR_RXRDY;
    end else if (tx_int_ff) begin
      isr_code = `URM_ISR_TRANSMIT_READY_EVENT;
    end else if (ier_ff[3] & |msr_ff) begin
      isr_code = `URM_ISR_MODEM;
    end else begin
      isr_code = `URM_ISR_NONE;
    end
  end

  // Polled mode falls out: all enables low keeps the line quiet, save a line-status interrupt still pending
  assign nxt_irq = lsr_int_ff | (ier_ff[0] & rx_avail) | tx_int_ff |
                   (ier_ff[3] & |msr_ff);

  // Read data mux
  always_comb begin
    nxt_rd_data = `URM_RST_BYTE;
    unique case (addr_i)
      `URM_A_DATA: begin
        if (bank == urm_pkg::URM_BANK_ENHANCED) begin
          nxt_rd_data = enhanced_mode_select_ff[`URM_ENHANCED_MODE_SELECT_CNT_BIT] ? tx_level_i : rx_level_i;
        end else if (bank == urm_pkg::URM_BANK_DIVISOR) begin
          nxt_rd_data = div_zero ? `URM_REV_VAL : div_low_ff;
        end else begin
          nxt_rd_data = rx_data_i;
        end
      end
      `URM_A_IER: begin
        if (bank == urm_pkg::URM_BANK_ENHANCED) nxt_rd_data = feature_control_ff;
        else if (bank == urm_pkg::URM_BANK_DIVISOR) nxt_rd_data = div_zero ? `URM_IDENT_VAL : div_high_ff;
        else nxt_rd_data = ier_ff;
      end
      `URM_A_ISR: begin
        if (bank == urm_pkg::URM_BANK_ENHANCED) nxt_rd_data = efr_ff;
        else if (bank == urm_pkg::URM_BANK_DIVISOR && enh) nxt_rd_data = {4'h0, frac_ff};
        else nxt_rd_data = {{2{fifo_enable_o}}, isr_code};
      end
      `URM_A_LCR: nxt_rd_data = lcr_ff;
      `URM_A_MCR: nxt_rd_data = (bank == urm_pkg::URM_BANK_ENHANCED) ? resume_char_one_ff : mcr_ff;
      `URM_A_LSR: nxt_rd_data = (bank == urm_pkg::URM_BANK_ENHANCED) ? resume_char_two_ff : lsr_val;
      `URM_A_MSR: nxt_rd_data = (bank == urm_pkg::URM_BANK_ENHANCED) ? pause_char_one_ff : {modem_level_i, msr_ff};
      `URM_A_SPR: begin
        if (bank == urm_pkg::URM_BANK_ENHANCED) nxt_rd_data = pause_char_two_ff;
        else if (feature_control_ff[`URM_FEATURE_CONTROL_SWAP_BIT]) nxt_rd_data = rx_level_i;
        else nxt_rd_data = spr_ff;
      end
    endcase
  end

  // Registered outputs
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= `URM_RST_BYTE;
      irq_o <= 1'b0;
      divisor_o <= 16'h0000;
      fraction_o <= 4'h0;
      line_control_o <= `URM_RST_LCR;
      modem_control_o <= `URM_RST_BYTE;
      fifo_enable_o <= 1'b0;
      rx_trigger_o <= `URM_RST_TRIG;
      tx_write_o <= 1'b0;
      tx_data_o <= `URM_RST_BYTE;
      rx_read_o <= 1'b0;
    end else begin
      if (rd) rd_data_o <= nxt_rd_data;
      irq_o <= nxt_irq;
      divisor_o <= {div_high_ff, div_low_ff};
      fraction_o <= frac_ff;
      line_control_o <= lcr_ff;
      modem_control_o <= mcr_ff;
      fifo_enable_o <= fcr_ff[`URM_FCR_EN_BIT];
      rx_trigger_o <= trig_lvl;
      tx_write_o <= thr_wr;
      if (thr_wr) tx_data_o <= wr_data_i;
      rx_read_o <= rhr_rd;
    end
  end

  // Checks
  a_rx_trig_irq: assert property (@(posedge clock_i) disable iff (rst_i)
    (fifo_enable_o && ier_ff[0] && rx_level_i >= trig_lvl) |=> irq_o)
    else $error("receive trigger did not raise interrupt");
  a_polled_quiet: assert property (@(posedge clock_i) disable iff (rst_i)
    (ier_ff[3:0] == 4'h0 && !lsr_int_ff && !tx_int_ff) |=> !irq_o)
    else $error("interrupt raised in polled mode");
  a_overrun_held: assert property (@(posedge clock_i) disable iff (rst_i)
    (rx_overrun_i && !lsr_rd) |=> overrun_ff ##1 (overrun_ff || $past(lsr_rd)))
    else $error("overrun flag lost");
  a_tx_enable_now: assert property (@(posedge clock_i) disable iff (rst_i)
    (wr && addr_i == `URM_A_IER && bank == urm_pkg::URM_BANK_NORMAL && wr_data_i[1] &&
     !ier_ff[1] && tx_hold_empty_i) |=> tx_int_ff ##1 irq_o)
    else $error("transmit ready not raised on enable");
  a_lsr_rd_clear: assert property (@(posedge clock_i) disable iff (rst_i)
    (lsr_rd && !(ier_ff[2] && err_event)) |=> !lsr_int_ff)
    else $error("line status read did not clear interrupt");
  a_tx_clear: assert property (@(posedge clock_i) disable iff (rst_i)
    (tx_int_ff && thr_wr && !(tx_cond && !tx_cond_ff)) |=> !tx_int_ff)
    else $error("transmit holding write did not clear");
  a_div_locked: assert property (@(posedge clock_i) disable iff (rst_i)
    (wr && addr_i == `URM_A_DATA && bank != urm_pkg::URM_BANK_DIVISOR) |=> $stable(div_low_ff))
    else $error("divisor changed while locked");
  a_frac_gate: assert property (@(posedge clock_i) disable iff (rst_i)
    (wr && !enh) |=> $stable(frac_ff) && $stable(ier_ff[7:4]))
    else $error("enhanced bits changed while disabled");
  a_ident_read: assert property (@(posedge clock_i) disable iff (rst_i)
    (rd && addr_i == `URM_A_IER && bank == urm_pkg::URM_BANK_DIVISOR && div_zero)
    |=> rd_data_o == `URM_IDENT_VAL)
    else $error("ident byte not returned");
  a_modem_irq: assert property (@(posedge clock_i) disable iff (rst_i)
    (ier_ff[3] && |msr_ff) |=> irq_o)
    else $error("modem status did not interrupt");
  a_enh_only: assert property (@(posedge clock_i) disable iff (rst_i)
    (wr && addr_i == `URM_A_SPR && bank != urm_pkg::URM_BANK_ENHANCED) |=> $stable(pause_char_two_ff))
    else $error("enhanced register written outside enhanced code");
endmodule : urm_regmap
`default_nettype wire

// [urm_host_model.sv]
// Host processor model for the register bus of one serial channel.
// Assumes the device samples cs, rd, wr, address and data on rising clock_i.
`timescale 1ns/1ps
`default_nettype none
module urm_host_model (
  // Clock
  input wire logic clock_i,
  // Parallel register bus
  output logic cs_o,
  output logic rd_o,
  output logic wr_o,
  output logic [2:0] addr_o,
  output logic [7:0] data_o,
  input wire logic [7:0] rd_data_i
);
  initial begin
    cs_o = 1'b0;
    rd_o = 1'b0;
    wr_o = 1'b0;
    addr_o = 3'h0;
    data_o = 8'h00;
  end
  // Released lines flip so a stale value never passes for a live one
  task automatic idle();
    cs_o = 1'b0;
    rd_o = 1'b0;
    wr_o = 1'b0;
    addr_o = ~addr_o;
    data_o = ~data_o;
  endtask : idle
  // One access: request held over one rising edge, answer taken after it
  task automatic access(input logic w, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clock_i);
    cs_o = 1'b1;
    rd_o = !w;
    wr_o = w;
    addr_o = a;
    data_o = d;
    @(posedge clock_i);
    @(negedge clock_i);
    q = rd_data_i;
    idle();
  endtask : access
endmodule : urm_host_model
`default_nettype wire

// [uart_reg_map_and_int_enable_bench.sv]
// Self-checking bench for the register map and interrupt enable block.
// Assumes urm_regmap, urm_host_model and a 10 MHz clock; inputs move on falling edges.
`include "urm_params.svh"
`timescale 1ns/1ps
`default_nettype none
module uart_reg_map_and_int_enable_bench;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic cs, rd, wr;
  logic [2:0] addr;
  logic [7:0] wdata, rd_data_o, rx_data_i = 8'h00, rx_level_i = 8'h00, tx_level_i = 8'h00;
  logic irq_o, rx_loaded_i = 1'b0, rx_empty_i = 1'b1, rx_overrun_i = 1'b0, rx_fifo_err_i = 1'b0;
  logic [2:0] rx_new_err_i = 3'h0, rx_head_err_i = 3'h0;
  logic tx_hold_empty_i = 1'b1, tx_shift_empty_i = 1'b1, tx_below_trig_i = 1'b0;
  logic [3:0] modem_delta_i = 4'h0, modem_level_i = 4'h0, fraction_o;
  logic [15:0] divisor_o;
  logic [7:0] line_control_o, rx_trigger_o, tx_data_o, q, lo, hi;
  logic fifo_enable_o, tx_write_o, rx_read_o;
  logic [7:0] modem_control_o;
  logic [31:0] lfsr = 32'd68463;
  int compares = 0, miscompares = 0, cycles = 0;
  // Reference state of the register model
  int line_control = 'h03, enhanced_function = 0, msk = 0;
  always #50 clock_i = ~clock_i;
  urm_host_model host (.clock_i(clock_i), .cs_o(cs), .rd_o(rd), .wr_o(wr), .addr_o(addr), .data_o(wdata),
    .rd_data_i(rd_data_o));
  urm_regmap DUT (.clock_i(clock_i), .rst_i(rst_i), .cs_i(cs), .rd_i(rd), .wr_i(wr), .addr_i(addr),
    .wr_data_i(wdata), .rd_data_o(rd_data_o), .irq_o(irq_o), .rx_data_i(rx_data_i), .rx_level_i(rx_level_i),
    .tx_level_i(tx_level_i), .rx_loaded_i(rx_loaded_i), .rx_new_err_i(rx_new_err_i),
    .rx_head_err_i(rx_head_err_i), .rx_empty_i(rx_empty_i), .rx_overrun_i(rx_overrun_i),
    .rx_fifo_err_i(rx_fifo_err_i), .tx_hold_empty_i(tx_hold_empty_i), .tx_shift_empty_i(tx_shift_empty_i),
    .tx_below_trig_i(tx_below_trig_i), .modem_delta_i(modem_delta_i), .modem_level_i(modem_level_i),
    .divisor_o(divisor_o), .fraction_o(fraction_o), .line_control_o(line_control_o),
    .modem_control_o(modem_control_o), .fifo_enable_o(fifo_enable_o), .rx_trigger_o(rx_trigger_o),
    .tx_write_o(tx_write_o), .tx_data_o(tx_data_o), .rx_read_o(rx_read_o));
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction : rnd
  task automatic summarize();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // Write and keep the model in step; upper mask bits need the enhanced enable
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    host.access(1'b1, a, d, dummy);
    if (a == 3'h3) line_control = d;
    if (line_control == 'hbf && a == 3'h2) enhanced_function = d;
    if (line_control[7] == 0 && a == 3'h1) msk = enhanced_function[4] ? d : (d & 'h0f);
  endtask : wr_reg
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    host.access(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask : rdc
  // Interrupt settles within a couple of edges of its cause
  task automatic irq_chk(input logic e);
    repeat (3) @(negedge clock_i);
    chk(irq_o, e);
  endtask : irq_chk
  task automatic settle();
    repeat (2) @(negedge clock_i);
  endtask : settle
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    repeat (8) @(negedge clock_i);
    rst_i = 1'b0;
    chk(line_control_o, 16'h0003);
    chk(rx_trigger_o, 16'h0001);
    chk(divisor_o, 16'h0000);
    chk(irq_o, 1'b0);
    rdc(3'h1, 8'h00);
    // Upper modem control bits stay shut until the enhanced enable is set
    wr_reg(3'h4, 8'hff);
    settle();
    chk(modem_control_o, 16'h001f);
    wr_reg(3'h3, 8'h80);
    rdc(3'h0, `URM_REV_VAL);
    rdc(3'h1, `URM_IDENT_VAL);
    lo = rnd() | 8'h01;
    hi = rnd();
    wr_reg(3'h0, lo);
    wr_reg(3'h1, hi);
    settle();
    chk(divisor_o, {hi, lo});
    rdc(3'h0, lo);
    rdc(3'h1, hi);
    wr_reg(3'h2, 8'h04);
    settle();
    chk(fraction_o, 16'h0000);
    wr_reg(3'h3, 8'hbf);
    wr_reg(3'h0, 8'h04);
    wr_reg(3'h2, 8'h10);
    rdc(3'h2, 8'h10);
    rx_level_i = rnd();
    rdc(3'h0, rx_level_i);
    rx_level_i = 8'h00;
    wr_reg(3'h1, 8'h40);
    settle();
    chk(divisor_o, {hi, lo});
    chk(rx_trigger_o, 16'h0004);
    wr_reg(3'h3, 8'h80);
    wr_reg(3'h2, 8'h0b);
    settle();
    chk(fraction_o, 16'h000b);
    wr_reg(3'h3, 8'h03);
    wr_reg(3'h4, 8'he5);
    settle();
    chk(modem_control_o, 16'h00e5);
    wr_reg(3'h7, 8'h00);
    wr_reg(3'h1, 8'hf0);
    rdc(3'h1, msk[7:0]);
    wr_reg(3'h1, 8'h02);
    irq_chk(1'b1);
    rdc(3'h2, 8'h02);
    irq_chk(1'b0);
    tx_hold_empty_i = 1'b0;
    @(negedge clock_i);
    tx_hold_empty_i = 1'b1;
    irq_chk(1'b1);
    wr_reg(3'h0, 8'h3c);
    chk(tx_write_o, 1'b1);
    irq_chk(1'b0);
    chk(tx_data_o, 16'h003c);
    wr_reg(3'h1, 8'h04);
    // Random status levels folded into line status
    repeat (4) begin
      q = rnd();
      {rx_empty_i, rx_head_err_i, tx_hold_empty_i, tx_shift_empty_i, rx_fifo_err_i} = q[6:0];
      // Nothing loaded yet, so data ready stays low whatever the empty level
      rdc(3'h5, {rx_fifo_err_i, tx_hold_empty_i & tx_shift_empty_i, tx_hold_empty_i, rx_head_err_i, 1'b0,
        1'b0});
    end
    {rx_head_err_i, rx_empty_i, rx_fifo_err_i} = 5'h00;
    {tx_hold_empty_i, tx_shift_empty_i} = 2'h3;
    irq_chk(1'b0);
    rx_overrun_i = 1'b1;
    @(negedge clock_i);
    rx_overrun_i = 1'b0;
    irq_chk(1'b1);
    host.access(1'b0, 3'h5, 8'h00, q);
    chk(q[1], 1'b1);
    irq_chk(1'b0);
    rx_new_err_i = 3'h2;
    rx_loaded_i = 1'b1;
    @(negedge clock_i);
    rx_loaded_i = 1'b0;
    irq_chk(1'b0);
    rx_head_err_i = 3'h2;
    rx_data_i = rnd();
    host.access(1'b0, 3'h0, 8'h00, q);
    chk(rx_read_o, 1'b1);
    chk(q, rx_data_i);
    irq_chk(1'b1);
    // Loaded character keeps data ready up; both transmit empties high
    rdc(3'h5, 8'h69);
    irq_chk(1'b0);
    wr_reg(3'h1, 8'h05);
    irq_chk(1'b1);
    wr_reg(3'h1, 8'h04);
    irq_chk(1'b0);
    rx_head_err_i = 3'h0;
    wr_reg(3'h7, 8'h40);
    rx_new_err_i = 3'h4;
    rx_loaded_i = 1'b1;
    @(negedge clock_i);
    rx_loaded_i = 1'b0;
    irq_chk(1'b1);
    host.access(1'b0, 3'h5, 8'h00, q);
    irq_chk(1'b0);
    wr_reg(3'h1, 8'h08);
    modem_level_i = 4'ha;
    modem_delta_i = 4'h4;
    @(negedge clock_i);
    modem_delta_i = 4'h0;
    irq_chk(1'b1);
    rdc(3'h6, 8'ha4);
    irq_chk(1'b0);
    wr_reg(3'h2, 8'h01);
    settle();
    chk(fifo_enable_o, 1'b1);
    wr_reg(3'h1, 8'h01);
    rx_level_i = 8'h03;
    irq_chk(1'b0);
    rx_level_i = 8'h04;
    irq_chk(1'b1);
    rdc(3'h2, 8'hc4);
    rx_level_i = 8'h03;
    irq_chk(1'b0);
    wr_reg(3'h1, 8'h00);
    rx_level_i = 8'h08;
    rx_overrun_i = 1'b1;
    modem_delta_i = 4'h1;
    @(negedge clock_i);
    rx_overrun_i = 1'b0;
    modem_delta_i = 4'h0;
    irq_chk(1'b0);
    host.access(1'b0, 3'h5, 8'h00, q);
    chk(q[1:0], 2'h3);
    summarize();
  end
endmodule : uart_reg_map_and_int_enable_bench
`default_nettype wire
